// ==== baud_rate_generator.sv ====
// Baud rate generator top with divisor registers and interrupt gating.
// Assumes a strobe register port, one-cycle read data, and flags from the
// receiver logic of the same interface instance.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module baud_rate_generator
    import baud_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic break_detect_flag,
    input wire logic rx_edge_flag,
    output logic [7:0] rdata,
    output logic sample_tick,
    output logic bit_tick,
    output logic receiver_enable,
    output logic transmitter_enable,
    output logic flag_irq,
    output logic irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg_req_t req;
    logic [7:0] high_buffer;
    logic [7:0] baud_divisor_high_and_irq_enables;
    logic [7:0] baud_divisor_low;
    logic [DIV_W-1:0] baud_divisor;
    logic started;
    logic [3:0] ovs_count;
    logic raw_tick;
    logic run;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] events;
    logic irq_int;
    logic break_ie;
    logic edge_ie;
    logic flag_req;
    logic [7:0] next_rdata;
    logic bit_end;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic wr_high, wr_low, wr_ctrl, wr_mask, rd_status;
    assign wr_high = req.wr && (req.addr == OFS_BAUD_HIGH);
    assign wr_low = req.wr && (req.addr == OFS_BAUD_LOW);
    assign wr_ctrl = req.wr && (req.addr == OFS_CONTROL);
    assign wr_mask = req.wr && (req.addr == OFS_IRQ_MASK);
    assign rd_status = req.rd && (req.addr == OFS_IRQ_STATUS);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            high_buffer <= RST_BAUD_HIGH;
        else if (wr_high)
            high_buffer <= req.wdata;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baud_divisor_high_and_irq_enables <= RST_BAUD_HIGH;
            baud_divisor_low <= RST_BAUD_LOW;
        end
        else if (wr_low)
        begin
            baud_divisor_high_and_irq_enables <= wr_high ? req.wdata : high_buffer;
            baud_divisor_low <= req.wdata;
        end
    end

    assign baud_divisor = {baud_divisor_high_and_irq_enables[DIV_HIGH_W-1:0],
                           baud_divisor_low};

    // Enables and mask
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            receiver_enable <= 1'b0;
            transmitter_enable <= 1'b0;
            mask <= {EV_W{1'b0}};
        end
        else
        begin
            if (wr_ctrl)
            begin
                receiver_enable <= req.wdata[BIT_RX_EN];
                transmitter_enable <= req.wdata[BIT_TX_EN];
            end
            if (wr_mask)
                mask <= req.wdata[EV_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            started <= 1'b0;
        else if (wr_ctrl && (req.wdata[BIT_RX_EN] || req.wdata[BIT_TX_EN]))
            started <= 1'b1;
    end

    assign run = started;

    baud_counter #(
        .WIDTH(DIV_W)
    ) u_counter (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(run),
        .divisor(baud_divisor),
        .tick(raw_tick)
    );

    assign bit_end = raw_tick && (ovs_count == OVS_LAST);
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            ovs_count <= OVS_ZERO;
        else if (!run || baud_divisor == DIV_ZERO)
            ovs_count <= OVS_ZERO;
        else if (raw_tick)
            ovs_count <= ovs_count + OVS_ONE;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end
        else
        begin
            sample_tick <= raw_tick;
            bit_tick <= bit_end;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign break_ie = baud_divisor_high_and_irq_enables[BIT_BREAK_IE];
    assign edge_ie = baud_divisor_high_and_irq_enables[BIT_EDGE_IE];
    assign flag_req = (break_ie && break_detect_flag) || (edge_ie && rx_edge_flag);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            flag_irq <= 1'b0;
        else
            flag_irq <= flag_req;
    end

    assign events = {bit_end, rx_edge_flag, break_detect_flag};

    irq_collect #(
        .N(EV_W)
    ) u_irq (
        .mclk(mclk),
        .rst_b(rst_b),
        .events(events),
        .mask(mask),
        .clear_all(rd_status),
        .status(status),
        .irq(irq_int)
    );
    assign irq = irq_int;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = ZERO_BYTE;
        if (req.addr == OFS_BAUD_HIGH)
            next_rdata = baud_divisor_high_and_irq_enables;
        else if (req.addr == OFS_BAUD_LOW)
            next_rdata = baud_divisor_low;
        else if (req.addr == OFS_CONTROL)
            next_rdata = {6'h00, transmitter_enable, receiver_enable};
        else if (req.addr == OFS_IRQ_STATUS)
            next_rdata = {5'h00, status};
        else if (req.addr == OFS_IRQ_MASK)
            next_rdata = {5'h00, mask};
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= ZERO_BYTE;
        else if (req.rd)
            rdata <= next_rdata;
        else
            rdata <= ZERO_BYTE;
    end
endmodule : baud_rate_generator

// ==== baud_pkg.sv ====
// Constants, register map and carrier types for the baud rate generator.
// Assumes one 50 MHz bus clock and a plain strobe register port.
//
// Overview of operation
// - Divisor is thirteen bits: high register bits 4:0 over low register bits 7:0.
// - High write is buffered; working divisor updates only on a low write.
// - Divisor zero stops the generator completely; no ticks, no counting.
// - Divisor 1 to 8191 gives bit rate of bus clock over sixteen times divisor.
// - Low register resets to value with only bit 2 set.
// - After reset generator idles until receiver or transmitter enable written one.
// - Transmit and receive share one rate; each interface instance has its own.
// - High bit 7 enables interrupt while break-detect flag is set.
// - High bit 6 enables interrupt while receive-edge flag is set.
package baud_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] OFS_BAUD_HIGH = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_BAUD_LOW = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h4;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int DIV_W = 13;
    localparam int DIV_HIGH_W = 5;
    localparam int BIT_BREAK_IE = 7;
    localparam int BIT_EDGE_IE = 6;
    localparam int BIT_RX_EN = 0;
    localparam int BIT_TX_EN = 1;
    localparam int OVERSAMPLE = 16;
    localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
    localparam logic [7:0] RST_BAUD_LOW = 8'h04;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [DIV_W-1:0] DIV_ZERO = 13'h0000;
    localparam logic [DIV_W-1:0] DIV_ONE = 13'h0001;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_ZERO = 4'h0;
    localparam logic [3:0] OVS_ONE = 4'h1;

    // Interrupt status bit positions
    localparam int EV_BREAK = 0;
    localparam int EV_EDGE = 1;
    localparam int EV_BIT = 2;
    localparam int EV_W = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic sample_tick;
        logic bit_tick;
    } baud_ticks_t;

endpackage : baud_pkg

// ==== baud_counter.sv ====
// Modulo counter making the sixteen-times sample tick.
// Assumes divisor is stable or changes only between ticks safely.
`timescale 1ns/1ps
module baud_counter
    import baud_pkg::*;
#(
    parameter int WIDTH = DIV_W
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [WIDTH-1:0] divisor,
    output logic tick
);
    logic [WIDTH-1:0] count;
    logic div_zero;
    logic at_end;

    assign div_zero = (divisor == DIV_ZERO);
    assign at_end = (count >= divisor - DIV_ONE);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= DIV_ZERO;
            tick <= 1'b0;
        end
        else if (!run || div_zero)
        begin
            count <= DIV_ZERO;
            tick <= 1'b0;
        end
        else if (at_end)
        begin
            count <= DIV_ZERO;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + DIV_ONE;
            tick <= 1'b0;
        end
    end
endmodule : baud_counter

// ==== irq_collect.sv ====
// Sticky event status with mask, cleared by a read of the status register.
// Assumes events are one-cycle pulses in the bus clock domain.
`timescale 1ns/1ps
module irq_collect
    import baud_pkg::*;
#(
    parameter int N = EV_W
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [N-1:0] events,
    input wire logic [N-1:0] mask,
    input wire logic clear_all,
    output logic [N-1:0] status,
    output logic irq
);
    logic [N-1:0] next_status;

    // Set wins over clear
    assign next_status = (clear_all ? {N{1'b0}} : status) | events;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status <= {N{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            status <= next_status;
            irq <= |(next_status & mask);
        end
    end
endmodule : irq_collect

// ==== baud_rate_generator_monitor.sv ====
// Port checker for the baud rate generator.
// Assumes a bind onto baud_rate_generator.
`timescale 1ns/1ps
module baud_rate_generator_monitor
    import baud_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic break_detect_flag,
    input wire logic rx_edge_flag,
    input wire logic [7:0] rdata,
    input wire logic sample_tick,
    input wire logic bit_tick,
    input wire logic flag_irq
);
    logic [7:0] hb;
    logic [15:0] hl;
    logic go;
    wire [7:0] hw = hl[15:8];
    wire [7:0] lo = hl[7:0];
    wire [DIV_W-1:0] dv = {hw[4:0], lo};
    wire f = (hw[7] & break_detect_flag) | (hw[6] & rx_edge_flag);
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            hb <= 8'h00;
        else if (wr && addr == OFS_BAUD_HIGH)
            hb <= wdata;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            hl <= 16'h0004;
        else if (wr && addr == OFS_BAUD_LOW)
            hl <= {hb, wdata};
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            go <= 1'b0;
        else if (wr && addr == OFS_CONTROL && wdata[1:0] != 2'h0)
            go <= 1'b1;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_zero; (dv == DIV_ZERO)[*3] |-> !sample_tick; endproperty
    a_zero: assert property (p_zero) else $error("zero tick");
    property p_idle; !go |-> !sample_tick && !bit_tick; endproperty
    a_idle: assert property (p_idle) else $error("idle tick");
    property p_one; (go && dv == DIV_ONE)[*3] |-> sample_tick; endproperty
    a_one: assert property (p_one) else $error("tick missing");
    property p_five;
        sample_tick && dv == 13'h0005 && $past(dv, 2) == 13'h0005 |=> (!sample_tick)[*4];
    endproperty
    a_five: assert property (p_five) else $error("early tick");
    property p_bit; bit_tick |-> sample_tick; endproperty
    a_bit: assert property (p_bit) else $error("lone bit tick");
    property p_flag; flag_irq == $past(f); endproperty
    a_flag: assert property (p_flag) else $error("flag irq");
    property p_rdh; rd && addr == OFS_BAUD_HIGH |=> rdata == $past(hw); endproperty
    a_rdh: assert property (p_rdh) else $error("high read");
    property p_rdl; rd && addr == OFS_BAUD_LOW |=> rdata == $past(lo); endproperty
    a_rdl: assert property (p_rdl) else $error("low read");
    c_bit: cover property (bit_tick);
    c_flag: cover property (flag_irq);
    c_stop: cover property (go && dv == DIV_ZERO);
endmodule : baud_rate_generator_monitor

// ==== tb_top.sv ====
// Self-checking bench for the baud rate generator.
// Assumes package, design and monitor compiled first.
`timescale 1ns/1ps
module tb_top
    import baud_pkg::*;
;
    logic mclk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic break_detect_flag = 1'b0, rx_edge_flag = 1'b0;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic sample_tick, bit_tick, receiver_enable, transmitter_enable, flag_irq, irq;
    logic [15:0] v;
    int errors = 0, n_compared = 0, n;
    always #10 mclk = ~mclk;
    baud_rate_generator i_baud_rate_generator (
        .mclk(mclk),
        .rst_b(rst_b),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .break_detect_flag(break_detect_flag),
        .rx_edge_flag(rx_edge_flag),
        .rdata(rdata),
        .sample_tick(sample_tick),
        .bit_tick(bit_tick),
        .receiver_enable(receiver_enable),
        .transmitter_enable(transmitter_enable),
        .flag_irq(flag_irq),
        .irq(irq)
    );
    task automatic chk(input string s, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
            errors++;
        if (got !== exp)
            $display("ERROR %s expected %h seen %h", s, exp, got);
    endtask : chk
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        v = 16'(rdata);
    endtask : bus
    task automatic to_bit(input int lim, output int c);
        c = 0;
        do
        begin
            @(posedge mclk);
            #1;
            c++;
        end
        while (bit_tick !== 1'b1 && c < lim);
    endtask : to_bit
    task automatic complete_run();
        $display("checks %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic t_regs();
        bus(1'b0, 3'h1, 8'h00);
        chk("low", v, 16'h0004);
        bus(1'b0, 3'h5, 8'h00);
        chk("unmapped", v, 16'h0000);
        bus(1'b1, 3'h0, 8'h15);
        bus(1'b0, 3'h0, 8'h00);
        chk("high", v, 16'h0000);
        bus(1'b1, 3'h1, 8'h80);
        bus(1'b0, 3'h0, 8'h00);
        chk("high", v, 16'h0015);
        to_bit(200, n);
        chk("idle", 16'(n), 16'h00C8);
        $display("regs done");
    endtask : t_regs
    task automatic t_rate();
        logic [15:0] dv [3] = '{16'h0001, 16'h0005, 16'h0102};
        bus(1'b1, 3'h2, 8'h01);
        chk("enables", 16'({receiver_enable, transmitter_enable}), 16'h0002);
        bus(1'b1, 3'h2, 8'h03);
        chk("enables", 16'({receiver_enable, transmitter_enable}), 16'h0003);
        bus(1'b0, 3'h2, 8'h00);
        chk("control", v, 16'h0003);
        foreach (dv[i])
        begin
            bus(1'b1, 3'h0, dv[i][15:8]);
            bus(1'b1, 3'h1, dv[i][7:0]);
            to_bit(9000, n);
            to_bit(9000, n);
            chk("period", 16'(n), dv[i] * 16'h0010);
        end
        $display("rate done");
    endtask : t_rate
    task automatic t_irq();
        logic [7:0] hi [3] = '{8'hC0, 8'hC0, 8'h40};
        logic [3:0] cs [3] = '{4'hB, 4'h6, 4'h9};
        bus(1'b1, 3'h4, 8'h01);
        bus(1'b0, 3'h4, 8'h00);
        chk("mask", v, 16'h0001);
        foreach (hi[i])
        begin
            bus(1'b1, 3'h0, hi[i]);
            bus(1'b1, 3'h1, 8'h05);
            bus(1'b0, 3'h3, 8'h00);
            @(posedge mclk);
            {break_detect_flag, rx_edge_flag} <= cs[i][3:2];
            @(posedge mclk);
            {break_detect_flag, rx_edge_flag} <= 2'h0;
            #1;
            chk("flag", 16'(flag_irq), 16'(cs[i][1]));
            chk("irq", 16'(irq), 16'(cs[i][0]));
            bus(1'b0, 3'h3, 8'h00);
            chk("status", v & 16'h0003, 16'({cs[i][2], cs[i][3]}));
        end
        $display("irq done");
    endtask : t_irq
    task automatic t_zero();
        bus(1'b1, 3'h0, 8'h00);
        bus(1'b1, 3'h1, 8'h00);
        repeat (2) @(posedge mclk);
        to_bit(200, n);
        chk("stop", 16'(n), 16'h00C8);
        $display("zero done");
    endtask : t_zero
    initial
    begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_rate();
        t_irq();
        t_zero();
        complete_run();
    end
    initial
    begin
        repeat (40000) @(posedge mclk);
        errors++;
        complete_run();
    end
endmodule : tb_top
bind baud_rate_generator baud_rate_generator_monitor i_baud_rate_generator_monitor (
    .mclk(mclk),
    .rst_b(rst_b),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .break_detect_flag(break_detect_flag),
    .rx_edge_flag(rx_edge_flag),
    .rdata(rdata),
    .sample_tick(sample_tick),
    .bit_tick(bit_tick),
    .flag_irq(flag_irq)
);
